// [include/elb_pkg.sv]
// Constants and types for the encoder loss bit evaluator
// Operation
// - Select 224..255: top 256-n bits grouped
// - Select 208..223: top 224-n low-half bits
// - Group, polarity 0: loss when all zero
// - Group, polarity 1: loss when any one
// - Negative select stored as 256 minus value
// - Full-scale samples keep magnitude top bits clear
// - Source pointer zero disables loss evaluation
// - Counter up on loss, down to zero
// - Error once counter exceeds trip limit
package elb_pkg;

  // ****************************************
  // Bus map (byte addresses)
  // ****************************************
  localparam logic [7:0] ADDR_SRC_PTR   = 8'h00;
  localparam logic [7:0] ADDR_BIT_SEL   = 8'h04;
  localparam logic [7:0] ADDR_POLARITY  = 8'h08;
  localparam logic [7:0] ADDR_TRIP_LIM  = 8'h0C;
  localparam logic [7:0] ADDR_STATUS    = 8'h10;
  localparam logic [7:0] ADDR_MAGNITUDE = 8'h14;
  localparam logic [7:0] ADDR_CONTROL   = 8'h18;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int STAT_ERR_BIT   = 0;
  localparam int STAT_LAST_BIT  = 1;
  localparam int STAT_CNT_LSB   = 16;
  localparam int CTRL_CLEAR_BIT = 0;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [15:0] RST_SRC_PTR  = 16'h0000;
  localparam logic [7:0]  RST_BIT_SEL  = 8'h00;
  localparam logic        RST_POLARITY = 1'b0;
  localparam logic [15:0] RST_TRIP_LIM = 16'h0000;

  // ****************************************
  // Selection ranges
  // ****************************************
  localparam logic [8:0]  SEL_WORD_BASE = 9'h0E0;
  localparam logic [8:0]  SEL_HALF_BASE = 9'h0D0;
  localparam logic [8:0]  SEL_SINGLE_LIM = 9'h020;
  localparam logic [15:0] PTR_DISABLED  = 16'h0000;
  localparam logic [15:0] PTR_INTERNAL  = 16'hFFFF;

  // ****************************************
  // Magnitude
  // ****************************************
  localparam logic [31:0] MAG_FULL_SCALE = 32'h4000_0000;

  typedef enum {
    ELB_IDLE,
    ELB_FETCH
  } elb_state_t;

endpackage : elb_pkg

// [core/elb_loss_eval.sv]
// Combinational loss test of one source word
`timescale 1ns/1ns
`default_nettype none
module elb_loss_eval (
  // Selection
  input  wire logic [7:0]  bit_select_i,
  input  wire logic        polarity_i,
  // Source word
  input  wire logic [31:0] word_i,
  // Result
  output logic             loss_o
);

  logic [31:0] group_mask;
  logic [8:0]  sel_ext;
  logic        single_mode;
  logic        group_mode;

  assign sel_ext     = {1'b0, bit_select_i};
  assign single_mode = sel_ext < elb_pkg::SEL_SINGLE_LIM;
  assign group_mode  = sel_ext >= elb_pkg::SEL_HALF_BASE;

  // ****************************************
  // Group mask per bit
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < 32; gi = gi + 1) begin : g_mask
      localparam logic [8:0] IDX = 9'(gi);
      always_comb begin
        if (sel_ext >= elb_pkg::SEL_WORD_BASE) begin
          group_mask[gi] = IDX >= (sel_ext - elb_pkg::SEL_WORD_BASE);
        end else if (sel_ext >= elb_pkg::SEL_HALF_BASE) begin
          group_mask[gi] = (gi < 16) && (IDX >= (sel_ext - elb_pkg::SEL_HALF_BASE));
        end else begin
          group_mask[gi] = 1'b0;
        end
      end
    end
  endgenerate

  always_comb begin
    if (single_mode) begin
      loss_o = word_i[bit_select_i[4:0]] == polarity_i;
    end else if (group_mode && !polarity_i) begin
      loss_o = (word_i & group_mask) == 32'h0000_0000;
    end else if (group_mode) begin
      loss_o = (word_i & group_mask) != 32'h0000_0000;
    end else begin
      loss_o = 1'b0;
    end
  end

endmodule : elb_loss_eval
`default_nettype wire

// [core/elb_evaluator.sv]
// Per-motor encoder loss evaluator with Avalon-MM registers
//
// Chosen here: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module elb_evaluator #(
  parameter int CNT_W = 16
) (
  // Clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        arst_n_i,
  // Avalon-MM slave
  input  wire logic [7:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o,
  // Scan tick
  input  wire logic        scan_tick_i,
  // Feedback interface read port
  output logic             src_read_o,
  output logic [15:0]      src_addr_o,
  input  wire logic [31:0] src_data_i,
  input  wire logic        src_valid_i,
  // Converted sine and cosine samples
  input  wire logic [15:0] sin_sample_i,
  input  wire logic [15:0] cos_sample_i,
  input  wire logic        sample_valid_i,
  // Fault side
  output logic             scan_done_o,
  output logic             scan_loss_o,
  output logic             loss_error_o
);

  typedef struct packed {
    elb_pkg::elb_state_t state;
    logic                bus_done;
    logic [31:0]         rdata;
    logic [15:0]         src_ptr;
    logic [7:0]          bit_sel;
    logic                polarity;
    logic [15:0]         trip_lim;
    logic [CNT_W-1:0]    count;
    logic                error;
    logic                last_loss;
    logic                fetch;
    logic [15:0]         fetch_addr;
    logic [31:0]         magnitude;
    logic                done_pulse;
    logic                loss_pulse;
  } elb_regs_t;

  elb_regs_t r;
  elb_regs_t next_r;

  logic        bus_req;
  logic        wr_go;
  logic [31:0] status_word;
  logic [31:0] eval_word;
  logic        eval_loss;
  logic        result_ready;
  logic [31:0] sin_sq;
  logic [31:0] cos_sq;
  logic [32:0] mag_sum;
  logic [CNT_W-1:0] cnt_max;

  // ****************************************
  // Evaluator instance
  // ****************************************
  elb_loss_eval u_eval (
    .bit_select_i (r.bit_sel),
    .polarity_i   (r.polarity),
    .word_i       (eval_word),
    .loss_o       (eval_loss)
  );

  // ****************************************
  // Magnitude from samples
  // ****************************************
  assign sin_sq  = 32'($signed(sin_sample_i) * $signed(sin_sample_i));
  assign cos_sq  = 32'($signed(cos_sample_i) * $signed(cos_sample_i));
  assign mag_sum = {1'b0, sin_sq} + {1'b0, cos_sq};

  assign bus_req     = avs_read_i | avs_write_i;
  assign wr_go       = avs_write_i & r.bus_done;
  assign cnt_max     = '1;
  assign eval_word   = (r.src_ptr == elb_pkg::PTR_INTERNAL) ? r.magnitude : src_data_i;
  // Counter in upper half, flags at bottom
  // Wider counters show only their low 16 bits
  assign status_word = {16'(r.count), 14'h0000, r.last_loss, r.error};

  assign result_ready = (r.state == elb_pkg::ELB_FETCH) &&
                        ((r.src_ptr == elb_pkg::PTR_INTERNAL) || src_valid_i);

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    next_r            = r;
    next_r.done_pulse = 1'b0;
    next_r.loss_pulse = 1'b0;

    // Bus slave, one wait state per access
    next_r.bus_done = bus_req & ~r.bus_done;
    if (bus_req && !r.bus_done) begin
      case (avs_address_i)
        elb_pkg::ADDR_SRC_PTR:   next_r.rdata = {16'h0000, r.src_ptr};
        elb_pkg::ADDR_BIT_SEL:   next_r.rdata = {24'h000000, r.bit_sel};
        elb_pkg::ADDR_POLARITY:  next_r.rdata = {31'h00000000, r.polarity};
        elb_pkg::ADDR_TRIP_LIM:  next_r.rdata = {16'h0000, r.trip_lim};
        elb_pkg::ADDR_STATUS:    next_r.rdata = status_word;
        elb_pkg::ADDR_MAGNITUDE: next_r.rdata = r.magnitude;
        default:                 next_r.rdata = 32'h0000_0000;
      endcase
    end

    if (sample_valid_i) begin
      // full-scale magnitude keeps top two bits clear
      // Clamp one below full scale
      // A full-range pair would otherwise set bit 31
      if (mag_sum >= {1'b0, elb_pkg::MAG_FULL_SCALE}) begin
        next_r.magnitude = elb_pkg::MAG_FULL_SCALE - 32'h0000_0001;
      end else begin
        next_r.magnitude = mag_sum[31:0];
      end
    end

    // ****************************************
    // Scan sequencing
    // ****************************************
    case (r.state)
      elb_pkg::ELB_IDLE: begin
        if (scan_tick_i && r.src_ptr != elb_pkg::PTR_DISABLED) begin
          next_r.state      = elb_pkg::ELB_FETCH;
          next_r.fetch      = r.src_ptr != elb_pkg::PTR_INTERNAL;
          next_r.fetch_addr = r.src_ptr;
        end
      end
      elb_pkg::ELB_FETCH: begin
        if (result_ready) begin
          next_r.state      = elb_pkg::ELB_IDLE;
          next_r.fetch      = 1'b0;
          next_r.done_pulse = 1'b1;
          next_r.loss_pulse = eval_loss;
          next_r.last_loss  = eval_loss;
          // count up on loss, down to zero otherwise
          if (eval_loss) begin
            if (r.count != cnt_max) begin
              next_r.count = r.count + CNT_W'(1);
            end
          end else if (r.count != '0) begin
            next_r.count = r.count - CNT_W'(1);
          end
        end
      end
      default: begin
        next_r.state = elb_pkg::ELB_IDLE;
        next_r.fetch = 1'b0;
      end
    endcase

    // ****************************************
    // Register writes
    // ****************************************
    if (wr_go && avs_byteenable_i != 4'h0) begin
      case (avs_address_i)
        elb_pkg::ADDR_SRC_PTR: begin
          next_r.src_ptr = avs_writedata_i[15:0];
        end
        elb_pkg::ADDR_BIT_SEL: begin
          // negative value wraps to 256 minus magnitude
          next_r.bit_sel = avs_writedata_i[7:0];
        end
        elb_pkg::ADDR_POLARITY: begin
          next_r.polarity = avs_writedata_i[0];
        end
        elb_pkg::ADDR_TRIP_LIM: begin
          next_r.trip_lim = avs_writedata_i[15:0];
        end
        elb_pkg::ADDR_CONTROL: begin
          if (avs_writedata_i[elb_pkg::CTRL_CLEAR_BIT]) begin
            next_r.error = 1'b0;
            if (!result_ready) begin
              next_r.count = '0;
            end
          end
        end
        default: begin
        end
      endcase
    end

    // trip once count exceeds limit, set beats clear
    if ({{(32 - CNT_W){1'b0}}, next_r.count} > {16'h0000, r.trip_lim}) begin
      next_r.error = 1'b1;
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      r            <= '0;
      r.state      <= elb_pkg::ELB_IDLE;
      r.src_ptr    <= elb_pkg::RST_SRC_PTR;
      r.bit_sel    <= elb_pkg::RST_BIT_SEL;
      r.polarity   <= elb_pkg::RST_POLARITY;
      r.trip_lim   <= elb_pkg::RST_TRIP_LIM;
    end else begin
      r <= next_r;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign avs_readdata_o    = r.rdata;
  assign avs_waitrequest_o = bus_req & ~r.bus_done;
  assign src_read_o        = r.fetch;
  assign src_addr_o        = r.fetch_addr;
  assign scan_done_o       = r.done_pulse;
  assign scan_loss_o       = r.loss_pulse;
  assign loss_error_o      = r.error;

endmodule : elb_evaluator
`default_nettype wire

// [test/elb_evaluator_props.sv]
// Port checker for the loss evaluator
`timescale 1ns/1ns
`default_nettype none
module elb_evaluator_props (
  // Watched ports
  input wire logic        core_clk_i,
  input wire logic        arst_n_i,
  input wire logic [7:0]  avs_address_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic        avs_waitrequest_o,
  input wire logic        src_read_o,
  input wire logic [15:0] src_addr_o,
  input wire logic        src_valid_i,
  input wire logic        scan_done_o,
  input wire logic        scan_loss_o,
  input wire logic        loss_error_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);
  // ****
  // Bus and scan timing
  // ****
  property p_rd_wait; $rose(avs_read_i) |-> avs_waitrequest_o ##1 !avs_waitrequest_o; endproperty
  property p_wr_wait; $rose(avs_write_i) |-> avs_waitrequest_o ##1 !avs_waitrequest_o; endproperty
  property p_fetch_hold; src_read_o && !src_valid_i |=> src_read_o; endproperty
  property p_addr_hold; src_read_o && !src_valid_i |=> $stable(src_addr_o); endproperty
  property p_fetch_end; src_read_o && src_valid_i |=> !src_read_o && scan_done_o; endproperty
  property p_done_pulse; scan_done_o |=> !scan_done_o; endproperty
  property p_loss_done; scan_loss_o |-> scan_done_o; endproperty
  property p_err_cause;
    $rose(loss_error_o) |-> (scan_done_o && scan_loss_o) ||
      $past(avs_write_i && avs_address_i == elb_pkg::ADDR_TRIP_LIM, 2);
  endproperty
  property p_err_hold;
    loss_error_o && !(avs_write_i && avs_address_i == elb_pkg::ADDR_CONTROL) |=> loss_error_o;
  endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
  a_wr_wait: assert property (p_wr_wait) else $error("write wait state wrong");
  a_fetch_hold: assert property (p_fetch_hold) else $error("fetch dropped early");
  a_addr_hold: assert property (p_addr_hold) else $error("fetch address moved");
  a_fetch_end: assert property (p_fetch_end) else $error("no result after data");
  a_done_pulse: assert property (p_done_pulse) else $error("done longer than one cycle");
  a_loss_done: assert property (p_loss_done) else $error("loss without done");
  a_err_cause: assert property (p_err_cause) else $error("error without loss scan");
  a_err_hold: assert property (p_err_hold) else $error("error dropped");
  c_loss: cover property (scan_loss_o);
  c_clean: cover property (scan_done_o && !scan_loss_o);
  c_trip: cover property ($rose(loss_error_o));
endmodule : elb_evaluator_props
bind elb_evaluator elb_evaluator_props u_props (
  .core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_waitrequest_o(avs_waitrequest_o),
  .src_read_o(src_read_o), .src_addr_o(src_addr_o), .src_valid_i(src_valid_i),
  .scan_done_o(scan_done_o), .scan_loss_o(scan_loss_o), .loss_error_o(loss_error_o));
`default_nettype wire

// [test/elb_fb_model.sv]
// Feedback interface model answering source fetches
`timescale 1ns/1ns
`default_nettype none
module elb_fb_model (
  // Clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        arst_n_i,
  // Fetch port
  input  wire logic        rd_i,
  input  wire logic [31:0] word_i,
  input  wire logic [1:0]  delay_i,
  output logic [31:0]      data_o,
  output logic             valid_o
);
  logic [1:0] cnt;
  // Answer after delay_i+1 cycles, data churn when idle
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt <= 2'h0;
      valid_o <= 1'b0;
      data_o <= 32'h0;
    end else if (valid_o || !rd_i) begin
      cnt <= 2'h0;
      valid_o <= 1'b0;
      data_o <= ~data_o;
    end else if (cnt == delay_i) begin
      valid_o <= 1'b1;
      data_o <= word_i;
    end else begin
      cnt <= cnt + 2'h1;
      data_o <= ~data_o;
    end
  end
endmodule : elb_fb_model
`default_nettype wire

// [test/tb_top.sv]
// Self-checking bench for the loss evaluator
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic        core_clk_i, arst_n_i, rd, wr, wt, tick, srd, sval, sv, done, loss, err;
  logic [7:0]  adr;
  logic [31:0] wdat, rdat, sdat, fw, got;
  logic [15:0] sadr, sn, cs;
  logic [1:0]  fd;
  int          bad_count, n_compared;
  // Select, polarity, source word, expected loss
  logic [41:0] cases [15] = '{
    {8'h0D, 1'b0, 32'hFFFFDFFF, 1'b1},
    {8'h0D, 1'b0, 32'h00002000, 1'b0},
    {8'h1C, 1'b1, 32'h10000000, 1'b1},
    {8'h1F, 1'b1, 32'h80000000, 1'b1},
    {8'h1F, 1'b1, 32'h7FFFFFFF, 1'b0},
    {8'h05, 1'b1, 32'hFFFFFFDF, 1'b0},
    {8'hF8, 1'b0, 32'h00FFFFFF, 1'b1},
    {8'hF8, 1'b0, 32'h01000000, 1'b0},
    {8'hDA, 1'b0, 32'hFFFF03FF, 1'b1},
    {8'hDA, 1'b0, 32'h00000400, 1'b0},
    {8'hDF, 1'b1, 32'hFFFF7FFF, 1'b0},
    {8'hFD, 1'b1, 32'h20000000, 1'b1},
    {8'hFD, 1'b1, 32'h1FFFFFFF, 1'b0},
    {8'hFC, 1'b1, 32'h10000000, 1'b1},
    {8'hE0, 1'b0, 32'h00000000, 1'b1}};
  logic [7:0]  rst_adr [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h1C};
  elb_evaluator u_dut (
    .core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .avs_address_i(adr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wdat), .avs_byteenable_i(4'hF), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wt), .scan_tick_i(tick), .src_read_o(srd), .src_addr_o(sadr),
    .src_data_i(sdat), .src_valid_i(sval), .sin_sample_i(sn), .cos_sample_i(cs),
    .sample_valid_i(sv), .scan_done_o(done), .scan_loss_o(loss), .loss_error_o(err));
  elb_fb_model u_fb (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .rd_i(srd), .word_i(fw),
    .delay_i(fd), .data_o(sdat), .valid_o(sval));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    rd <= !w;
    wr <= w;
    adr <= a;
    wdat <= d;
    do @(posedge core_clk_i); while (wt !== 1'b0);
    got = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus
  task automatic scan(input logic [31:0] w, input logic exp, input logic fin);
    int k;
    @(posedge core_clk_i);
    fw <= w;
    tick <= 1'b1;
    @(posedge core_clk_i);
    tick <= 1'b0;
    for (k = 0; k < 12 && done !== 1'b1; k++) @(negedge core_clk_i);
    check({30'h0, done, loss}, {30'h0, fin, exp});
  endtask : scan
  task automatic complete_run;
    $display("compared %0d mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run
  initial begin
    core_clk_i = 1'b0;
    forever #4 core_clk_i = ~core_clk_i;
  end
  initial begin
    repeat (20000) @(posedge core_clk_i);
    bad_count++;
    complete_run();
  end
  initial begin
    {arst_n_i, rd, wr, tick, sv, adr, wdat, fw, sn, cs, fd} = '0;
    repeat (5) @(posedge core_clk_i);
    arst_n_i <= 1'b1;
    foreach (rst_adr[i]) begin
      bus(1'b0, rst_adr[i], 32'h0);
      check(got, 32'h0);
    end
    scan(32'h0, 1'b0, 1'b0);
    bus(1'b0, elb_pkg::ADDR_STATUS, 32'h0);
    check(got, 32'h0);
    bus(1'b1, elb_pkg::ADDR_SRC_PTR, 32'h40);
    bus(1'b1, elb_pkg::ADDR_TRIP_LIM, 32'hFFFF);
    foreach (cases[i]) begin
      fd <= 2'(i);
      bus(1'b1, elb_pkg::ADDR_BIT_SEL, {24'h0, cases[i][41:34]});
      bus(1'b1, elb_pkg::ADDR_POLARITY, {31'h0, cases[i][33]});
      scan(cases[i][32:1], cases[i][0], 1'b1);
      check({16'h0, sadr}, 32'h0000_0040);
    end
    bus(1'b1, elb_pkg::ADDR_BIT_SEL, 32'h1F);
    bus(1'b1, elb_pkg::ADDR_POLARITY, 32'h1);
    bus(1'b1, elb_pkg::ADDR_TRIP_LIM, 32'h2);
    bus(1'b1, elb_pkg::ADDR_CONTROL, 32'h1);
    for (int i = 1; i <= 3; i++) begin
      scan(32'h80000000, 1'b1, 1'b1);
      check({31'h0, err}, {31'h0, i == 3});
      bus(1'b0, elb_pkg::ADDR_STATUS, 32'h0);
      check(got, {16'(i), 14'h0, 1'b1, i == 3});
    end
    scan(32'h7FFFFFFF, 1'b0, 1'b1);
    bus(1'b1, elb_pkg::ADDR_STATUS, 32'hFFFFFFFF);
    bus(1'b0, elb_pkg::ADDR_STATUS, 32'h0);
    check(got, 32'h00020001);
    bus(1'b1, elb_pkg::ADDR_CONTROL, 32'h1);
    scan(32'h0, 1'b0, 1'b1);
    bus(1'b0, elb_pkg::ADDR_STATUS, 32'h0);
    check(got, 32'h0);
    bus(1'b1, elb_pkg::ADDR_BIT_SEL, 32'hFFFFFFFE);
    bus(1'b0, elb_pkg::ADDR_BIT_SEL, 32'h0);
    check(got, 32'h000000FE);
    bus(1'b1, elb_pkg::ADDR_POLARITY, 32'h0);
    bus(1'b1, elb_pkg::ADDR_SRC_PTR, 32'hFFFF);
    @(posedge core_clk_i);
    sn <= 16'h8000;
    sv <= 1'b1;
    @(posedge core_clk_i);
    sv <= 1'b0;
    bus(1'b0, elb_pkg::ADDR_MAGNITUDE, 32'h0);
    check(got, elb_pkg::MAG_FULL_SCALE - 32'h0000_0001);
    scan(32'hFFFFFFFF, 1'b1, 1'b1);
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
